/* File: bench/step_dir_microstep_sequencer_test.sv */
// Purpose: Self-checking bench of the microstep sequencer.
// Assumes: clk_en high except during one frozen step; host model makes step and dir.
// Notes: Short power-down tick keeps standstill waits brief.
`timescale 1ns/100ps
module step_dir_microstep_sequencer_test;
  import step_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic ms1_in = 1'b0;
  logic ms2_in = 1'b0;
  logic powerdown_serial_pin = 1'b1;
  logic ext_clk_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] rd;
  logic signed [AMP_W-1:0] coil_a_current;
  logic signed [AMP_W-1:0] coil_b_current;
  logic step_in, dir_in, index_out, standstill_out;
  logic freewheel_out, brake_out, ext_clk_sel;
  int num_errors = 0;
  int num_checks = 0;
  always #5 clk = !clk;
  step_host_model step_host_model_i (.clk(clk), .step_out(step_in),
    .dir_out(dir_in));
  step_dir_microstep_sequencer #(.PD_TICK_CYCLES(4))
    step_dir_microstep_sequencer_i (.clk, .rst_n, .clk_en, .step_in,
    .dir_in, .ms1_in, .ms2_in, .powerdown_serial_pin, .ext_clk_in,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .coil_a_current,
    .coil_b_current, .index_out, .standstill_out, .freewheel_out,
    .brake_out, .ext_clk_sel);
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic step(input logic dir, input logic tgl, input int hold);
    step_host_model_i.send(dir, tgl, hold);
  endtask
  task automatic t_reset;
    rd_reg(ADDR_STATUS);
    check("pos", rd[9:0], 0);
    check("index", rd[ST_INDEX_BIT], 1'b1);
    rd_reg(ADDR_CURRENT);
    check("current", rd, 32'h0014101F);
    check("coil b", coil_b_current, 9'sh0F0);
    check("coil a", coil_a_current, 9'sh000);
    rd_reg(8'h20);
    check("unmapped", rd, 0);
  endtask
  task automatic t_res;
    wr(ADDR_CONTROL, 32'h2);
    for (int c = 0; c <= 8; c++)
    begin
      wr(ADDR_RESOLUTION, c);
      step(1'b0, 1'b0, c + 1);
      rd_reg(ADDR_STATUS);
      check("pos up", rd[9:0], 1 << c);
      check("res", rd[23:20], c);
      check("index off", index_out, 1'b0);
      step(1'b1, 1'b0, 1);
      rd_reg(ADDR_STATUS);
      check("pos down", rd[9:0], 0);
      check("index on", index_out, 1'b1);
    end
    wr(ADDR_RESOLUTION, 0);
    step(1'b1, 1'b0, 1);
    rd_reg(ADDR_STATUS);
    check("wrap", rd[9:0], 10'h3FF);
    check("coil sign", coil_a_current < 0, 1'b1);
    step(1'b0, 1'b0, 1);
  endtask
  task automatic t_pins;
    logic [3:0] code [4] = '{RES_PIN_8, RES_PIN_2, RES_PIN_4, RES_PIN_16};
    wr(ADDR_CONTROL, 0);
    for (int i = 0; i < 4; i++)
    begin
      {ms2_in, ms1_in} <= 2'(i);
      step(1'b0, 1'b0, 1);
      rd_reg(ADDR_STATUS);
      check("pin res", rd[23:20], code[i]);
      check("pin pos", rd[9:0], 1 << code[i]);
      step(1'b1, 1'b0, 1);
    end
  endtask
  task automatic t_double_edge_step_select;
    wr(ADDR_CONTROL, 32'h3);
    wr(ADDR_RESOLUTION, 0);
    repeat (2) step(1'b0, 1'b1, 1);
    wr(ADDR_CONTROL, 32'h2);
    repeat (2) step(1'b0, 1'b1, 1);
    rd_reg(ADDR_STATUS);
    check("edges", rd[9:0], 3);
    clk_en <= 1'b0;
    step(1'b0, 1'b0, 1);
    clk_en <= 1'b1;
    rd_reg(ADDR_STATUS);
    check("frozen", rd[9:0], 3);
    repeat (3) step(1'b1, 1'b0, 1);
  endtask
  task automatic t_still;
    wr(ADDR_CONTROL, 0);
    wr(ADDR_CURRENT, 32'h0002081F);
    powerdown_serial_pin <= 1'b0;
    step(1'b0, 1'b0, 1);
    @(posedge clk);
    step(1'b1, 1'b0, 1);
    repeat (5) @(posedge clk);
    #1 check("moving", standstill_out, 1'b0);
    repeat (10) @(posedge clk);
    #1 check("still", standstill_out, 1'b1);
    check("auto hold", coil_b_current, 9'sh07C);
    wr(ADDR_CONTROL, 32'h40);
    repeat (3) @(posedge clk);
    #1 check("manual hold", coil_b_current, 9'sh03E);
    wr(ADDR_CONTROL, 32'h10);
    repeat (3) @(posedge clk);
    #1 check("freewheel", freewheel_out, 1'b1);
    wr(ADDR_CONTROL, 32'h20);
    repeat (3) @(posedge clk);
    #1 check("brake", brake_out, 1'b1);
    wr(ADDR_CONTROL, 32'h2);
    repeat (3) @(posedge clk);
    #1 check("pin ignored", coil_b_current, 9'sh0F0);
    wr(ADDR_CONTROL, 0);
    powerdown_serial_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("pin high", coil_b_current, 9'sh0F0);
  endtask
  task automatic t_gen;
    logic [9:0] p;
    wr(ADDR_CONTROL, 32'h2);
    wr(ADDR_VELOCITY, 32'h400000);
    step(1'b1, 1'b0, 1);
    repeat (36) @(posedge clk);
    wr(ADDR_VELOCITY, 0);
    rd_reg(ADDR_STATUS);
    p = rd[9:0];
    check("gen up", p >= 9 && p <= 12, 1'b1);
    wr(ADDR_VELOCITY, 32'hC00000);
    repeat (40) @(posedge clk);
    wr(ADDR_VELOCITY, 0);
    rd_reg(ADDR_STATUS);
    check("gen down", 10'(p - rd[9:0]) inside {[9:12]}, 1'b1);
    p = rd[9:0] + 10'h001;
    step(1'b0, 1'b0, 1);
    rd_reg(ADDR_STATUS);
    check("shared", rd[9:0], p);
  endtask
  task automatic t_clk;
    repeat (10)
    begin
      @(posedge clk);
      ext_clk_in <= !ext_clk_in;
      @(posedge clk);
    end
    #1 check("ext on", ext_clk_sel, 1'b1);
    repeat (190) @(posedge clk);
    #1 check("ext held", ext_clk_sel, 1'b1);
    repeat (20) @(posedge clk);
    #1 check("ext lost", ext_clk_sel, 1'b0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_res;
    t_pins;
    t_double_edge_step_select;
    t_still;
    t_gen;
    t_clk;
    tally_and_finish;
  end
endmodule

/* File: bench/step_host_model.sv */
// Purpose: Host model driving the step and direction pins.
// Assumes: Pins change just after a rising clk edge.
// Notes: Direction drops to its pull-down level after each step.
`timescale 1ns/100ps
module step_host_model
(
  input wire logic clk,
  output logic step_out,
  output logic dir_out
);
  initial
  begin
    step_out = 1'b0;
    dir_out = 1'b0;
  end
  ////////////////////////////////////////
  // One step edge; toggle gives a falling edge when step is high
  task automatic send(input logic dir, input logic toggle, input int hold);
    @(posedge clk);
    dir_out <= dir;
    @(posedge clk);
    step_out <= toggle ? !step_out : 1'b1;
    repeat (hold) @(posedge clk);
    if (!toggle)
      step_out <= 1'b0;
    @(posedge clk);
    dir_out <= 1'b0;
  endtask
endmodule

/* File: bench/step_seq_monitor.sv */
// Purpose: Port checker of the microstep sequencer.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every sequencer instance.
`timescale 1ns/100ps
module step_seq_monitor
#(
  parameter int PD_TICK_CYCLES = step_seq_pkg::PD_TICK_CYCLES_DFLT
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step_in,
  input wire logic ext_clk_in,
  input wire logic signed [step_seq_pkg::AMP_W-1:0] coil_a_current,
  input wire logic signed [step_seq_pkg::AMP_W-1:0] coil_b_current,
  input wire logic index_out,
  input wire logic standstill_out,
  input wire logic freewheel_out,
  input wire logic brake_out,
  input wire logic ext_clk_sel
);
  import step_seq_pkg::*;
  localparam int TO_LATE = CLK_TIMEOUT_CYCLES + 3;
  localparam int TO_EARLY = CLK_TIMEOUT_CYCLES - 3;
  logic ext_prev_reg;
  logic [8:0] quiet_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Cycles since the external clock pin last moved
  always_ff @(posedge clk)
  begin
    ext_prev_reg <= ext_clk_in;
    if (!rst_n || ext_clk_in != ext_prev_reg)
      quiet_reg <= 9'h000;
    else if (quiet_reg != 9'h1FF)
      quiet_reg <= quiet_reg + 9'h001;
  end
  property p_reset_home;
    $rose(rst_n) |-> index_out && coil_a_current == 9'sh000;
  endproperty
  a_reset_home: assert property (p_reset_home)
    else $error("index or coil off after reset");
  property p_ext_seen;
    $changed(ext_clk_in) |-> ##[1:3] ext_clk_sel;
  endproperty
  a_ext_seen: assert property (p_ext_seen)
    else $error("external clock not selected");
  property p_ext_lost;
    quiet_reg >= TO_LATE |-> !ext_clk_sel;
  endproperty
  a_ext_lost: assert property (p_ext_lost)
    else $error("no fallback to internal clock");
  property p_ext_held;
    ext_clk_sel && quiet_reg < TO_EARLY |=> ext_clk_sel;
  endproperty
  a_ext_held: assert property (p_ext_held)
    else $error("external clock dropped early");
  property p_step_wakes;
    $rose(step_in) |-> ##[1:4] !standstill_out;
  endproperty
  a_step_wakes: assert property (p_step_wakes)
    else $error("step did not leave standstill");
  property p_freewheel_still;
    freewheel_out |-> standstill_out || $past(standstill_out);
  endproperty
  a_freewheel_still: assert property (p_freewheel_still)
    else $error("freewheel outside standstill");
  property p_brake_still;
    brake_out |-> (standstill_out || $past(standstill_out)) && !freewheel_out;
  endproperty
  a_brake_still: assert property (p_brake_still)
    else $error("brake outside standstill");
  property p_coil_bound;
    coil_a_current <= 9'sh0F8 && coil_a_current >= -9'sh0F8 &&
      coil_b_current <= 9'sh0F8 && coil_b_current >= -9'sh0F8;
  endproperty
  a_coil_bound: assert property (p_coil_bound)
    else $error("coil target beyond table range");
endmodule
bind step_dir_microstep_sequencer step_seq_monitor #(
  .PD_TICK_CYCLES(PD_TICK_CYCLES)
) step_seq_monitor_i (.clk(clk), .rst_n(rst_n), .step_in(step_in),
  .ext_clk_in(ext_clk_in), .coil_a_current(coil_a_current),
  .coil_b_current(coil_b_current), .index_out(index_out),
  .standstill_out(standstill_out), .freewheel_out(freewheel_out),
  .brake_out(brake_out), .ext_clk_sel(ext_clk_sel));

/* File: rtl/sine_rom.sv */
// Purpose: Sine and cosine lookup of the microstep position.
// Assumes: Position spans 4 * QUARTER entries, one electrical period.
// Notes: Quarter wave built at elaboration; outputs are registered.
`timescale 1ns/100ps
module sine_rom
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [step_seq_pkg::POS_W-1:0] position,
  output logic signed [step_seq_pkg::AMP_W-1:0] sine_out,
  output logic signed [step_seq_pkg::AMP_W-1:0] cosine_out
);
  import step_seq_pkg::*;

  // Fixed point Taylor series, x in Q16 over 0..pi/2
  function automatic int sin_val(input int i);
    longint x;
    longint x2;
    longint t;
    longint s;
    x = (longint'(i) * 64'd102944) / QUARTER;
    x2 = (x * x) >>> 16;
    t = x;
    s = x;
    t = (t * x2) >>> 16;
    s = s - t / 6;
    t = (t * x2) >>> 16;
    s = s + t / 120;
    t = (t * x2) >>> 16;
    s = s - t / 5040;
    t = (t * x2) >>> 16;
    s = s + t / 362880;
    return int'((s * SINE_AMP + 32768) >>> 16);
  endfunction

  logic [7:0] tab [0:QUARTER];

  genvar g;
  generate
    for (g = 0; g <= QUARTER; g++)
    begin : g_tab
      assign tab[g] = 8'(sin_val(g));
    end
  endgenerate

  // Fold the quadrant onto the quarter wave
  function automatic logic signed [AMP_W-1:0] fold(
    input logic [POS_W-1:0] p
  );
    logic [8:0] idx;
    logic [AMP_W-1:0] mag;
    idx = p[8] ? 9'(9'h100 - {1'b0, p[7:0]}) : {1'b0, p[7:0]};
    mag = {1'b0, tab[idx]};
    return p[9] ? -signed'(mag) : signed'(mag);
  endfunction

  logic [POS_W-1:0] cos_pos;
  assign cos_pos = POS_W'(position + POS_W'(QUARTER));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sine_out <= '0;
      cosine_out <= '0;
    end
    else if (clk_en)
    begin
      sine_out <= fold(position);
      cosine_out <= fold(cos_pos);
    end
  end

endmodule

/* File: rtl/step_dir_microstep_sequencer.sv */
// Purpose: Step/direction microstep sequencer with step generator.
// Assumes: All pins synchronous to clk; registers on a plain port.
// Notes: Coil targets lag the position counter by two cycles.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
// Functional notes
// R01 - Rising step edges count; both edges count with double-edge select set.
// R02 - Direction is sampled at each active step edge; host keeps it valid.
// R03 - Resolution is fullstep or 2 to 256 microsteps per fullstep.
// R04 - Direction low counts up, high counts down, by resolution step size.
// R05 - Position drives a sine/cosine table setting both coil targets.
// R06 - Index output marks position zero, once per four fullsteps.
// R07 - Position counter starts at zero after reset.
// R08 - Internal generator takes direction from velocity sign.
// R09 - Generator steps at programmed velocity without ramp; host ramps.
// R10 - External and internal stepping share the one position counter.
// R11 - Stalled external clock times out and falls back to internal.
// R12 - Grounded power-down pin enables standstill reduction by default.
// R13 - Automatic standstill level is slightly above half run current.
// R14 - Hold current, delay, freewheel or braking configurable at standstill.
// R15 - Control bit lets registers override pin mode selection.
// R16 - Position wraps modulo one electrical period in both directions.
// R17 - Power-down delay starts at last step, restarts on each step.
module step_dir_microstep_sequencer
#(
  parameter int PD_TICK_CYCLES = step_seq_pkg::PD_TICK_CYCLES_DFLT
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic ms1_in,
  input wire logic ms2_in,
  input wire logic powerdown_serial_pin,
  input wire logic ext_clk_in,
  input wire logic [step_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [step_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [step_seq_pkg::DATA_W-1:0] reg_rdata,
  output logic signed [step_seq_pkg::AMP_W-1:0] coil_a_current,
  output logic signed [step_seq_pkg::AMP_W-1:0] coil_b_current,
  output logic index_out,
  output logic standstill_out,
  output logic freewheel_out,
  output logic brake_out,
  output logic ext_clk_sel
);
  import step_seq_pkg::*;

  localparam int TICK_W = $clog2(PD_TICK_CYCLES + 1);
  localparam int TO_W = $clog2(CLK_TIMEOUT_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(PD_TICK_CYCLES - 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(CLK_TIMEOUT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic double_edge_step_select_reg;
  logic pin_dis_reg;
  logic pd_en_reg;
  logic [1:0] mode_reg;
  logic hold_man_reg;
  logic [3:0] res_reg;
  logic signed [VEL_W-1:0] vel_reg;
  logic [CUR_W-1:0] run_reg;
  logic [CUR_W-1:0] hold_reg;
  logic [DELAY_W-1:0] delay_reg;

  logic wr_ctrl;
  logic wr_res;
  logic wr_vel;
  logic wr_cur;
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CONTROL);
  assign wr_res = reg_wr && (reg_addr == ADDR_RESOLUTION);
  assign wr_vel = reg_wr && (reg_addr == ADDR_VELOCITY);
  assign wr_cur = reg_wr && (reg_addr == ADDR_CURRENT);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      double_edge_step_select_reg <= 1'b0;
      pin_dis_reg <= 1'b0;
      pd_en_reg <= 1'b0;
      mode_reg <= SS_REDUCE;
      hold_man_reg <= 1'b0;
    end
    else if (clk_en && wr_ctrl)
    begin
      double_edge_step_select_reg <= reg_wdata[CTL_DOUBLE_EDGE_BIT];
      pin_dis_reg <= reg_wdata[CTL_PIN_DIS_BIT];
      pd_en_reg <= reg_wdata[CTL_PD_EN_BIT];
      mode_reg <= reg_wdata[CTL_MODE_LSB +: 2];
      hold_man_reg <= reg_wdata[CTL_HOLD_MAN_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      res_reg <= RES_RST;
      vel_reg <= VEL_RST;
      run_reg <= RUN_RST;
      hold_reg <= HOLD_RST;
      delay_reg <= DELAY_RST;
    end
    else if (clk_en)
    begin
      if (wr_res)
        res_reg <= reg_wdata[3:0];
      if (wr_vel)
        vel_reg <= reg_wdata[VEL_W-1:0];
      if (wr_cur)
      begin
        run_reg <= reg_wdata[CUR_RUN_LSB +: CUR_W];
        hold_reg <= reg_wdata[CUR_HOLD_LSB +: CUR_W];
        delay_reg <= reg_wdata[CUR_DELAY_LSB +: DELAY_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resolution and mode selection
  logic [3:0] pin_res;
  logic [3:0] reg_res;
  logic [3:0] res_eff;
  logic [POS_W-1:0] step_size;
  logic pd_auto_en;
  assign pin_res = ms2_in ? (ms1_in ? RES_PIN_16 : RES_PIN_4)
                          : (ms1_in ? RES_PIN_2 : RES_PIN_8);
  assign reg_res = (res_reg > RES_CODE_MAX) ? RES_CODE_MAX : res_reg; // [R03]
  assign res_eff = pin_dis_reg ? reg_res : pin_res; // [R15]
  assign step_size = POS_W'(1) << res_eff; // [R03]
  // Grounded pin requests reduction unless registers override
  assign pd_auto_en = pin_dis_reg ? pd_en_reg : ~powerdown_serial_pin; // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Step sources
  logic step_prev_reg;
  logic [VEL_W-1:0] acc_reg;
  logic step_rise;
  logic step_fall;
  logic int_active;
  logic ext_step;
  logic [VEL_W-1:0] vel_mag;
  logic [VEL_W:0] acc_sum;
  logic int_step;
  logic step_any;
  logic step_back;

  assign step_rise = step_in & ~step_prev_reg;
  assign step_fall = ~step_in & step_prev_reg;
  assign int_active = |vel_reg; // [R10]
  assign ext_step = ~int_active & (step_rise
                  | (double_edge_step_select_reg & step_fall)); // [R01]
  assign vel_mag = vel_reg[VEL_W-1] ? VEL_W'(-vel_reg) : VEL_W'(vel_reg);
  assign acc_sum = {1'b0, acc_reg} + {1'b0, vel_mag}; // [R09]
  assign int_step = int_active & acc_sum[VEL_W]; // [R09]
  assign step_any = ext_step | int_step; // [R10]
  // Generator ignores the pin; the pin is read only in its edge cycle
  assign step_back = int_active ? vel_reg[VEL_W-1] : dir_in; // [R02] [R08]

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      step_prev_reg <= 1'b0;
      acc_reg <= '0;
    end
    else if (clk_en)
    begin
      step_prev_reg <= step_in;
      acc_reg <= int_active ? acc_sum[VEL_W-1:0] : '0; // [R09]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position counter and index
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;
  logic index_next;

  assign pos_next = !step_any ? pos_reg
                  : step_back ? POS_W'(pos_reg - step_size)
                  : POS_W'(pos_reg + step_size); // [R04] [R16]
  assign index_next = pos_next < step_size; // [R06]

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pos_reg <= POS_ZERO; // [R07]
      index_out <= 1'b1; // [R07]
    end
    else if (clk_en)
    begin
      pos_reg <= pos_next;
      index_out <= index_next; // [R06]
    end
  end

  logic signed [AMP_W-1:0] sine_val;
  logic signed [AMP_W-1:0] cosine_val;

  sine_rom u_sine_rom
  (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .position(pos_reg),
    .sine_out(sine_val),
    .cosine_out(cosine_val)
  ); // [R05]

  ////////////////////////////////////////////////////////////////////////////
  // Standstill detection
  pd_state_e pd_state_reg;
  pd_state_e pd_state_next;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [DELAY_W-1:0] delay_cnt_reg;
  logic tick;
  logic delay_done;

  assign tick = tick_cnt_reg == TICK_LAST;
  assign delay_done = delay_cnt_reg >= delay_reg; // [R14]

  always_comb
  begin
    pd_state_next = pd_state_reg;
    case (pd_state_reg)
      PD_MOVING:
        if (!step_any && delay_done)
          pd_state_next = PD_STILL;
      PD_STILL:
        if (step_any)
          pd_state_next = PD_MOVING; // [R17]
      default:
        pd_state_next = PD_MOVING;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pd_state_reg <= PD_MOVING;
      tick_cnt_reg <= '0;
      delay_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      pd_state_reg <= pd_state_next;
      if (step_any || tick)
        tick_cnt_reg <= '0; // [R17]
      else
        tick_cnt_reg <= TICK_W'(tick_cnt_reg + 1'b1);
      if (step_any)
        delay_cnt_reg <= '0; // [R17]
      else if (tick && !delay_done)
        delay_cnt_reg <= DELAY_W'(delay_cnt_reg + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coil current scaling
  logic [CUR_W-1:0] auto_hold;
  logic [CUR_W-1:0] hold_level;
  logic reduce;
  logic [CUR_W-1:0] cur_sel;
  logic signed [CUR_W:0] cur_s;
  logic signed [AMP_W+CUR_W:0] prod_a;
  logic signed [AMP_W+CUR_W:0] prod_b;

  // Half the run current plus one step, never above run current
  assign auto_hold = ((run_reg >> 1) < run_reg) ?
                     CUR_W'((run_reg >> 1) + 1'b1) : run_reg; // [R13]
  assign hold_level = hold_man_reg ? hold_reg : auto_hold; // [R14]
  assign reduce = pd_auto_en && (pd_state_reg == PD_STILL); // [R12]
  assign cur_sel = !reduce ? run_reg
                 : (mode_reg == SS_REDUCE) ? hold_level : '0; // [R14]
  assign cur_s = signed'({1'b0, cur_sel});
  assign prod_a = sine_val * cur_s; // [R05]
  assign prod_b = cosine_val * cur_s; // [R05]

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      coil_a_current <= '0;
      coil_b_current <= '0;
      standstill_out <= 1'b0;
      freewheel_out <= 1'b0;
      brake_out <= 1'b0;
    end
    else if (clk_en)
    begin
      coil_a_current <= prod_a[AMP_W+CUR_W-1:CUR_W]; // [R05]
      coil_b_current <= prod_b[AMP_W+CUR_W-1:CUR_W]; // [R05]
      standstill_out <= pd_state_reg == PD_STILL;
      freewheel_out <= reduce && (mode_reg == SS_FREEWHEEL); // [R14]
      brake_out <= reduce && (mode_reg == SS_BRAKE); // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External clock watchdog
  logic ext_prev_reg;
  logic [TO_W-1:0] to_cnt_reg;
  logic ext_toggle;
  logic timed_out;
  assign ext_toggle = ext_clk_in ^ ext_prev_reg;
  assign timed_out = to_cnt_reg == TO_LAST;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ext_prev_reg <= 1'b0;
      to_cnt_reg <= '0;
      ext_clk_sel <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_prev_reg <= ext_clk_in;
      if (ext_toggle)
      begin
        to_cnt_reg <= '0;
        ext_clk_sel <= 1'b1;
      end
      else if (timed_out)
        ext_clk_sel <= 1'b0; // [R11]
      else
        to_cnt_reg <= TO_W'(to_cnt_reg + 1'b1); // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  logic [DATA_W-1:0] rd_ctrl;
  logic [DATA_W-1:0] rd_cur;
  logic [DATA_W-1:0] rd_status;
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_ctrl = '0;
    rd_ctrl[CTL_DOUBLE_EDGE_BIT] = double_edge_step_select_reg;
    rd_ctrl[CTL_PIN_DIS_BIT] = pin_dis_reg;
    rd_ctrl[CTL_PD_EN_BIT] = pd_en_reg;
    rd_ctrl[CTL_MODE_LSB +: 2] = mode_reg;
    rd_ctrl[CTL_HOLD_MAN_BIT] = hold_man_reg;
    rd_cur = '0;
    rd_cur[CUR_RUN_LSB +: CUR_W] = run_reg;
    rd_cur[CUR_HOLD_LSB +: CUR_W] = hold_reg;
    rd_cur[CUR_DELAY_LSB +: DELAY_W] = delay_reg;
    rd_status = '0;
    rd_status[ST_POS_LSB +: POS_W] = pos_reg;
    rd_status[ST_STILL_BIT] = pd_state_reg == PD_STILL;
    rd_status[ST_INDEX_BIT] = index_out;
    rd_status[ST_EXTCLK_BIT] = ext_clk_sel;
    rd_status[ST_RES_LSB +: 4] = res_eff;
  end

  assign rd_mux = (reg_addr == ADDR_CONTROL) ? rd_ctrl
                : (reg_addr == ADDR_RESOLUTION) ? DATA_W'(res_reg)
                : (reg_addr == ADDR_VELOCITY) ? DATA_W'(unsigned'(vel_reg))
                : (reg_addr == ADDR_CURRENT) ? rd_cur
                : (reg_addr == ADDR_STATUS) ? rd_status
                : '0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_mux : '0;
  end

endmodule

/* File: rtl/step_seq_pkg.sv */
// Purpose: Shared constants and types of the microstep sequencer.
// Assumes: 100 MHz core clock, 32-bit register port.
// Notes: Position counter spans one electrical period of four fullsteps.
package step_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int POS_W = 10;
  localparam int VEL_W = 24;
  localparam int AMP_W = 9;
  localparam int CUR_W = 5;
  localparam int DELAY_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESOLUTION = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_VELOCITY = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;

  // Field positions
  localparam int CTL_DOUBLE_EDGE_BIT = 0;
  localparam int CTL_PIN_DIS_BIT = 1;
  localparam int CTL_PD_EN_BIT = 2;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_HOLD_MAN_BIT = 6;
  localparam int CUR_RUN_LSB = 0;
  localparam int CUR_HOLD_LSB = 8;
  localparam int CUR_DELAY_LSB = 16;
  localparam int ST_POS_LSB = 0;
  localparam int ST_STILL_BIT = 16;
  localparam int ST_INDEX_BIT = 17;
  localparam int ST_EXTCLK_BIT = 18;
  localparam int ST_RES_LSB = 20;

  // Reset values
  localparam logic [3:0] RES_RST = 4'h0;
  localparam logic [VEL_W-1:0] VEL_RST = 24'h000000;
  localparam logic [CUR_W-1:0] RUN_RST = 5'h1F;
  localparam logic [CUR_W-1:0] HOLD_RST = 5'h10;
  localparam logic [DELAY_W-1:0] DELAY_RST = 8'h14;
  localparam logic [POS_W-1:0] POS_ZERO = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Resolution codes: step size is 2**code, code 8 is fullstep
  localparam logic [3:0] RES_CODE_MAX = 4'h8;
  localparam logic [3:0] RES_PIN_8 = 4'h5;
  localparam logic [3:0] RES_PIN_2 = 4'h7;
  localparam logic [3:0] RES_PIN_4 = 4'h6;
  localparam logic [3:0] RES_PIN_16 = 4'h4;

  // Sine table
  localparam int QUARTER = 256;
  localparam int SINE_AMP = 248;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_TIMEOUT_NS = 2000;
  localparam int CLK_TIMEOUT_CYCLES = CLK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int PD_TICK_NS = 1000000;
  localparam int PD_TICK_CYCLES_DFLT = PD_TICK_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SS_REDUCE = 2'h0,
    SS_FREEWHEEL = 2'h1,
    SS_BRAKE = 2'h2
  } standstill_mode_e;

  typedef enum logic [1:0] {
    PD_MOVING = 2'b01,
    PD_STILL = 2'b10
  } pd_state_e;

endpackage
